// ==== include/hub_cfg_pkg.sv ====
package hub_cfg_pkg;

    localparam logic [7:0] ADDR_CFG_BYTE_TWO   = 8'h07;
    localparam logic [7:0] ADDR_CFG_BYTE_THREE = 8'h08;
    localparam logic [7:0] ADDR_FIXED_MASK     = 8'h09;
    localparam logic [7:0] ADDR_SELF_PWR_OFF   = 8'h0A;
    localparam logic [7:0] ADDR_BUS_PWR_OFF    = 8'h0B;

    localparam logic [7:0] RST_CFG_BYTE_TWO    = 8'h00;
    localparam logic [7:0] RST_CFG_BYTE_THREE  = 8'h00;
    localparam logic [7:0] RST_FIXED_MASK      = 8'h00;
    localparam logic [7:0] RST_PORT_OFF        = 8'h00;

    // Writable bits of each register; the rest are reserved and read as zero.
    localparam logic [7:0] WMASK_CFG_BYTE_TWO   = 8'hB8;
    localparam logic [7:0] WMASK_CFG_BYTE_THREE = 8'h0F;
    localparam logic [7:0] WMASK_PORT_BITS      = 8'h1E;

    localparam int OC_SEL_LSB      = 4;
    localparam int COMPOUND_BIT    = 3;
    localparam int REMAP_BIT       = 3;
    localparam int LED_PIN_MODE_LSB    = 1;
    localparam int STRING_BIT      = 0;

    localparam logic [1:0] LED_PIN_MODE_SPEED = 2'h1;
    localparam logic [1:0] SPEED_HIGH     = 2'h2;
    localparam logic [1:0] SPEED_FULL     = 2'h1;

    localparam int NUM_PORTS       = 4;
    localparam int OC_CNT_W        = 20;

    localparam int MCLK_PERIOD_NS  = 20;
    localparam int OC_DLY_CODE0_NS = 100000;
    localparam int OC_DLY_CODE1_NS = 4000000;
    localparam int OC_DLY_CODE2_NS = 8000000;
    localparam int OC_DLY_CODE3_NS = 16000000;
    localparam int OC_CYC_CODE0    = OC_DLY_CODE0_NS / MCLK_PERIOD_NS;
    localparam int OC_CYC_CODE1    = OC_DLY_CODE1_NS / MCLK_PERIOD_NS;
    localparam int OC_CYC_CODE2    = OC_DLY_CODE2_NS / MCLK_PERIOD_NS;
    localparam int OC_CYC_CODE3    = OC_DLY_CODE3_NS / MCLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic                report_compound;
        logic                report_led_support;
        logic                string_support_en;
        logic                port_remap_enable;
        logic [4:1]          reported_fixed_ports;
        logic [2:0]          enabled_port_count;
        logic [4:1][2:0]     logical_port_map;
    } hub_report_t;

    typedef struct packed {
        logic [7:0]                          cfg_byte_two_r;
        logic [7:0]                          cfg_byte_three_r;
        logic [7:0]                          fixed_port_mask_r;
        logic [7:0]                          self_pwr_port_off_mask_r;
        logic [7:0]                          bus_pwr_port_off_mask_r;
        logic [7:0]                          rdata_r;
        logic [NUM_PORTS-1:0][OC_CNT_W-1:0]  oc_cnt_r;
        logic [4:1]                          oc_valid_r;
        logic [4:1]                          led_first_n_r;
        logic [4:1]                          led_second_n_r;
        hub_report_t                         report_r;
    } cfg_state_t;

endpackage

// ==== src/hub_config_option_bytes.sv ====
`timescale 1ns/10ps
`default_nettype none

module hub_config_option_bytes #(
    parameter int OC_CYC_CODE0 = hub_cfg_pkg::OC_CYC_CODE0,
    parameter int OC_CYC_CODE1 = hub_cfg_pkg::OC_CYC_CODE1,
    parameter int OC_CYC_CODE2 = hub_cfg_pkg::OC_CYC_CODE2,
    parameter int OC_CYC_CODE3 = hub_cfg_pkg::OC_CYC_CODE3
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire hub_cfg_pkg::cfg_req_t   cfg_req,
    output logic [7:0]                   cfg_rdata,
    input  wire logic                    cfg_from_straps,
    input  wire logic [1:0]              fixed_port_straps,
    input  wire logic                    self_powered,
    input  wire logic [4:1]              port_connected,
    input  wire logic [4:1][1:0]         port_speed,
    input  wire logic [4:1]              oc_sense_n,
    output logic [4:1]                   oc_valid,
    output logic [4:1]                   port_led_first_n,
    output logic [4:1]                   port_led_second_n,
    output hub_cfg_pkg::hub_report_t     hub_report
);

    hub_cfg_pkg::cfg_state_t state_r;
    hub_cfg_pkg::cfg_state_t state_nxt;

    // Decoded option fields, taken from the registered bytes.
    logic [1:0]                       oc_sel;
    logic [hub_cfg_pkg::OC_CNT_W-1:0] oc_limit;
    logic [1:0]                       led_pin_mode;
    logic                             speed_leds;
    logic                             compound_bit;
    logic                             remap_on;
    logic                             string_on;

    // Register-port strobes, one per mapped address.
    logic                             wr_byte_two;
    logic                             wr_byte_three;
    logic                             wr_fixed_mask;
    logic                             wr_self_off;
    logic                             wr_bus_off;
    logic [7:0]                       wdata_byte_two;
    logic [7:0]                       wdata_byte_three;
    logic [7:0]                       wdata_port_bits;
    logic [7:0]                       rd_value;

    // Port-level views used by the reports and the LEDs.
    logic [4:1]                       strap_fixed;
    logic [4:1]                       mask_fixed;
    logic [4:1]                       fixed_ports;
    logic [4:1]                       power_off_mask;
    logic [4:1]                       port_off;
    logic [4:1]                       port_on;
    logic [2:0]                       next_logical;
    logic [4:1][2:0]                  port_map;
    logic [4:1]                       oc_low;
    logic [4:1]                       oc_full;
    logic [4:1]                       high_speed;
    logic [4:1]                       full_speed;

    always_comb begin
        state_nxt        = state_r;
        oc_sel           = state_r.cfg_byte_two_r[hub_cfg_pkg::OC_SEL_LSB +: 2];
        compound_bit     = state_r.cfg_byte_two_r[hub_cfg_pkg::COMPOUND_BIT];
        led_pin_mode         = state_r.cfg_byte_three_r[hub_cfg_pkg::LED_PIN_MODE_LSB +: 2];
        remap_on         = state_r.cfg_byte_three_r[hub_cfg_pkg::REMAP_BIT];
        string_on        = state_r.cfg_byte_three_r[hub_cfg_pkg::STRING_BIT];
        speed_leds       = (led_pin_mode == hub_cfg_pkg::LED_PIN_MODE_SPEED);
        wr_byte_two      = 1'b0;
        wr_byte_three    = 1'b0;
        wr_fixed_mask    = 1'b0;
        wr_self_off      = 1'b0;
        wr_bus_off       = 1'b0;
        wdata_byte_two   = cfg_req.wdata & hub_cfg_pkg::WMASK_CFG_BYTE_TWO;
        wdata_byte_three = cfg_req.wdata & hub_cfg_pkg::WMASK_CFG_BYTE_THREE;
        wdata_port_bits  = cfg_req.wdata & hub_cfg_pkg::WMASK_PORT_BITS;
        rd_value         = 8'h00;
        strap_fixed      = 4'h0;
        mask_fixed       = state_r.fixed_port_mask_r[4:1];
        fixed_ports      = 4'h0;
        power_off_mask   = 4'h0;
        port_off         = 4'h0;
        port_on          = 4'h0;
        next_logical     = 3'h0;
        port_map         = '0;
        oc_low           = ~oc_sense_n;
        oc_full          = 4'h0;
        high_speed       = 4'h0;
        full_speed       = 4'h0;

        // The delay counts are parameters so that a bench can shorten them without touching the logic.
        unique case (oc_sel)
            2'h0: begin
                oc_limit = hub_cfg_pkg::OC_CNT_W'(OC_CYC_CODE0);
            end
            2'h1: begin
                oc_limit = hub_cfg_pkg::OC_CNT_W'(OC_CYC_CODE1);
            end
            2'h2: begin
                oc_limit = hub_cfg_pkg::OC_CNT_W'(OC_CYC_CODE2);
            end
            2'h3: begin
                oc_limit = hub_cfg_pkg::OC_CNT_W'(OC_CYC_CODE3);
            end
        endcase

        // Each write strobe fires only for its own address; unmapped addresses fall through.
        if (cfg_req.wr) begin
            unique case (cfg_req.addr)
                hub_cfg_pkg::ADDR_CFG_BYTE_TWO: begin
                    wr_byte_two = 1'b1;
                end
                hub_cfg_pkg::ADDR_CFG_BYTE_THREE: begin
                    wr_byte_three = 1'b1;
                end
                hub_cfg_pkg::ADDR_FIXED_MASK: begin
                    wr_fixed_mask = 1'b1;
                end
                hub_cfg_pkg::ADDR_SELF_PWR_OFF: begin
                    wr_self_off = 1'b1;
                end
                hub_cfg_pkg::ADDR_BUS_PWR_OFF: begin
                    wr_bus_off = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Reserved bits are dropped at write time so that reads and reports never see them.
        if (wr_byte_two) begin
            state_nxt.cfg_byte_two_r = wdata_byte_two;
        end
        if (wr_byte_three) begin
            state_nxt.cfg_byte_three_r = wdata_byte_three;
        end
        if (wr_fixed_mask) begin
            state_nxt.fixed_port_mask_r = wdata_port_bits;
        end
        if (wr_self_off) begin
            state_nxt.self_pwr_port_off_mask_r = wdata_port_bits;
        end
        if (wr_bus_off) begin
            state_nxt.bus_pwr_port_off_mask_r = wdata_port_bits;
        end

        // Reads see the registered bytes, so a write in the same cycle is not yet visible.
        unique case (cfg_req.addr)
            hub_cfg_pkg::ADDR_CFG_BYTE_TWO: begin
                rd_value = state_r.cfg_byte_two_r;
            end
            hub_cfg_pkg::ADDR_CFG_BYTE_THREE: begin
                rd_value = state_r.cfg_byte_three_r;
            end
            hub_cfg_pkg::ADDR_FIXED_MASK: begin
                rd_value = state_r.fixed_port_mask_r;
            end
            hub_cfg_pkg::ADDR_SELF_PWR_OFF: begin
                rd_value = state_r.self_pwr_port_off_mask_r;
            end
            hub_cfg_pkg::ADDR_BUS_PWR_OFF: begin
                rd_value = state_r.bus_pwr_port_off_mask_r;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
        if (cfg_req.rd) begin
            state_nxt.rdata_r = rd_value;
        end

        // The straps name a count of fixed ports from port 1 upward, up to three, so port 4 can never be strapped fixed.
        unique case (fixed_port_straps)
            2'h0: begin
                strap_fixed = 4'h0;
            end
            2'h1: begin
                strap_fixed = 4'h1;
            end
            2'h2: begin
                strap_fixed = 4'h3;
            end
            2'h3: begin
                strap_fixed = 4'h7;
            end
        endcase

        if (cfg_from_straps) begin
            fixed_ports = strap_fixed;
        end else begin
            fixed_ports = mask_fixed;
        end

        // The power source picks between the two port-off masks, which apply only while remap is off.
        if (self_powered) begin
            power_off_mask = state_r.self_pwr_port_off_mask_r[4:1];
        end else begin
            power_off_mask = state_r.bus_pwr_port_off_mask_r[4:1];
        end
        if (!remap_on) begin
            port_off = power_off_mask;
        end
        port_on = ~port_off;

        // Enabled physical ports are packed into consecutive logical numbers.
        for (int p = 1; p <= hub_cfg_pkg::NUM_PORTS; p++) begin
            if (port_on[p]) begin
                next_logical = next_logical + 3'h1;
                port_map[next_logical] = 3'(p);
            end
        end

        // Speed of each attached device, as seen by the speed indication LEDs.
        for (int p = 1; p <= hub_cfg_pkg::NUM_PORTS; p++) begin
            high_speed[p] = port_connected[p] && (port_speed[p] == hub_cfg_pkg::SPEED_HIGH);
            full_speed[p] = port_connected[p] && (port_speed[p] == hub_cfg_pkg::SPEED_FULL);
        end

        // A glitch shorter than the delay restarts the count from zero. The count saturates at the
        // limit, and the compare is not an equality, so a shorter delay chosen mid-count still fires.
        for (int p = 1; p <= hub_cfg_pkg::NUM_PORTS; p++) begin
            oc_full[p] = (state_r.oc_cnt_r[p-1] >= oc_limit);
            if (oc_low[p]) begin
                if (!oc_full[p]) begin
                    state_nxt.oc_cnt_r[p-1] = state_r.oc_cnt_r[p-1] + 1'b1;
                end
            end else begin
                state_nxt.oc_cnt_r[p-1] = '0;
            end
            state_nxt.oc_valid_r[p] = oc_low[p] && oc_full[p];
        end

        // In USB mode the second LED follows the filtered over-current flag one cycle later.
        for (int p = 1; p <= hub_cfg_pkg::NUM_PORTS; p++) begin
            if (speed_leds) begin
                state_nxt.led_first_n_r[p]  = !high_speed[p];
                state_nxt.led_second_n_r[p] = !full_speed[p];
            end else begin
                state_nxt.led_first_n_r[p]  = !(port_connected[p] && port_on[p]);
                state_nxt.led_second_n_r[p] = !state_r.oc_valid_r[p];
            end
        end

        // Disabled ports are left out of the fixed-port report as well.
        state_nxt.report_r.logical_port_map     = port_map;
        state_nxt.report_r.enabled_port_count   = next_logical;
        state_nxt.report_r.reported_fixed_ports = fixed_ports & port_on;
        if (cfg_from_straps) begin
            state_nxt.report_r.report_compound = |fixed_ports;
        end else begin
            state_nxt.report_r.report_compound = compound_bit;
        end
        state_nxt.report_r.report_led_support = !speed_leds;
        state_nxt.report_r.string_support_en  = string_on;
        state_nxt.report_r.port_remap_enable  = remap_on;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r                          <= '0;
            state_r.cfg_byte_two_r           <= hub_cfg_pkg::RST_CFG_BYTE_TWO;
            state_r.cfg_byte_three_r         <= hub_cfg_pkg::RST_CFG_BYTE_THREE;
            state_r.fixed_port_mask_r        <= hub_cfg_pkg::RST_FIXED_MASK;
            state_r.self_pwr_port_off_mask_r <= hub_cfg_pkg::RST_PORT_OFF;
            state_r.bus_pwr_port_off_mask_r  <= hub_cfg_pkg::RST_PORT_OFF;
            state_r.led_first_n_r            <= 4'hF;
            state_r.led_second_n_r           <= 4'hF;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg_rdata         = state_r.rdata_r;
    assign oc_valid          = state_r.oc_valid_r;
    assign port_led_first_n  = state_r.led_first_n_r;
    assign port_led_second_n = state_r.led_second_n_r;
    assign hub_report        = state_r.report_r;

endmodule

`default_nettype wire

// ==== tb/hub_config_option_bytes_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module hub_cfg_properties (
    input wire logic                     mclk,
    input wire logic                     rst_b,
    input wire hub_cfg_pkg::cfg_req_t    cfg_req,
    input wire logic [7:0]               cfg_rdata,
    input wire logic                     cfg_from_straps,
    input wire logic [1:0]               fixed_port_straps,
    input wire logic [4:1]               oc_sense_n,
    input wire logic [4:1]               oc_valid,
    input wire hub_cfg_pkg::hub_report_t hub_report
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic w8;
    logic w7;
    assign w8 = cfg_req.wr && cfg_req.addr == hub_cfg_pkg::ADDR_CFG_BYTE_THREE;
    assign w7 = cfg_req.wr && cfg_req.addr == hub_cfg_pkg::ADDR_CFG_BYTE_TWO && !cfg_from_straps;
    mask_reserved_a: assert property (cfg_req.rd && cfg_req.addr == 8'h09 |=> cfg_rdata[7:5] == 3'h0 && !cfg_rdata[0])
        else $error("reserved mask bits read nonzero");
    byte_reserved_a: assert property (cfg_req.rd && cfg_req.addr == 8'h08 |=> cfg_rdata[7:4] == 4'h0)
        else $error("reserved option bits read nonzero");
    led_support_a: assert property (w8 && cfg_req.wdata[2:1] == 2'h1 ##1 !w8 |=> !hub_report.report_led_support)
        else $error("led support reported in speed mode");
    mode_set_a: assert property (w8 && cfg_req.wdata[3] && cfg_req.wdata[0] ##1 !w8 |=> hub_report.port_remap_enable && hub_report.string_support_en)
        else $error("remap or string not enabled");
    mode_clear_a: assert property (w8 && !cfg_req.wdata[3] && !cfg_req.wdata[0] ##1 !w8 |=> !hub_report.port_remap_enable && !hub_report.string_support_en)
        else $error("remap or string not disabled");
    compound_clear_a: assert property (w7 && !cfg_req.wdata[3] ##1 !cfg_req.wr && !cfg_from_straps |=> !hub_report.report_compound)
        else $error("compound reported while clear");
    strap_compound_a: assert property (cfg_from_straps && fixed_port_straps != 2'h0 |=> hub_report.report_compound)
        else $error("strapped fixed port without compound");
    oc_filter_a: assert property ($rose(oc_valid[1]) |-> !$past(oc_sense_n[1], 1) && !$past(oc_sense_n[1], 4))
        else $error("over-current accepted too early");
    oc_release_a: assert property (oc_sense_n[1] && oc_valid[1] |=> !oc_valid[1])
        else $error("over-current not released");
    cover property (w8 && cfg_req.wdata[2:1] == 2'h1);
    cover property ($rose(oc_valid[1]));
    cover property (cfg_from_straps && hub_report.report_compound);
endmodule
bind hub_config_option_bytes hub_cfg_properties i_hub_cfg_properties (.mclk, .rst_b, .cfg_req, .cfg_rdata,
    .cfg_from_straps, .fixed_port_straps, .oc_sense_n, .oc_valid, .hub_report);
`default_nettype wire

// ==== tb/hub_cfg_source.sv ====
`timescale 1ns/10ps
`default_nettype none
// Stands for the serial configuration source; it loads one option byte per access.
// The peripheral on a fixed port is not modelled, as it answers for its own descriptors.
module hub_cfg_source (
    input  wire logic            mclk,
    input  wire logic [7:0]      cfg_rdata,
    output var hub_cfg_pkg::cfg_req_t cfg_req
);
    initial cfg_req = '0;
    task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cfg_req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        cfg_req <= '0;
    endtask
    task automatic get_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        cfg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        cfg_req <= '0;
        #1 d = cfg_rdata;
    endtask
    // The mask goes first so the hub never reports a compound device without its fixed ports.
    task automatic put_compound(input logic [7:0] mask);
        put_byte(hub_cfg_pkg::ADDR_FIXED_MASK, mask);
        put_byte(hub_cfg_pkg::ADDR_CFG_BYTE_TWO, 8'h08);
    endtask
endmodule
`default_nettype wire

// ==== tb/hub_config_option_bytes_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module hub_config_option_bytes_tb;
    logic mclk = 1'b0, rst_b = 1'b0, from_straps = 1'b0, self_pwr = 1'b1;
    logic [1:0] straps = 2'h0;
    logic [4:1] conn = 4'h7, sense_n = 4'hF;
    logic [4:1][1:0] speed = 8'h06;
    wire hub_cfg_pkg::cfg_req_t req;
    wire hub_cfg_pkg::hub_report_t rpt;
    wire logic [7:0] rdata;
    wire logic [4:1] oc_valid, led1_n, led2_n;
    logic [7:0] d;
    int num_errors = 0, n_compared = 0;
    always #10 mclk = ~mclk;
    hub_cfg_source i_hub_cfg_source (.mclk(mclk), .cfg_rdata(rdata), .cfg_req(req));
    // Short filter counts keep the run brief; every over-current expectation below is derived from them.
    hub_config_option_bytes #(.OC_CYC_CODE0(3), .OC_CYC_CODE1(5), .OC_CYC_CODE2(7), .OC_CYC_CODE3(9))
        i_hub_config_option_bytes (.mclk(mclk), .rst_b(rst_b), .cfg_req(req), .cfg_rdata(rdata),
        .cfg_from_straps(from_straps), .fixed_port_straps(straps), .self_powered(self_pwr),
        .port_connected(conn), .port_speed(speed), .oc_sense_n(sense_n), .oc_valid(oc_valid),
        .port_led_first_n(led1_n), .port_led_second_n(led2_n), .hub_report(rpt));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pins(input logic fs, input logic [1:0] st, input logic sp);
        @(posedge mclk);
        from_straps <= fs;
        straps <= st;
        self_pwr <= sp;
        tick(2);
    endtask
    task automatic t_reset();
        check(rpt.report_led_support, 1'b1);
        check(rpt.report_compound, 1'b0);
        i_hub_cfg_source.get_byte(8'h0C, d);
        check(d, 8'h00);
    endtask
    task automatic t_byte3();
        for (int m = 0; m < 4; m++) begin
            i_hub_cfg_source.put_byte(8'h08, {4'hF, m[0], m[1:0], m[1]});
            tick(2);
            check(rpt.report_led_support, m != 1);
            check(rpt.port_remap_enable, m[0]);
            check(rpt.string_support_en, m[1]);
            check(led1_n, m == 1 ? 4'hE : 4'h8);
            check(led2_n, m == 1 ? 4'hD : 4'hF);
            i_hub_cfg_source.get_byte(8'h08, d);
            check(d, {4'h0, m[0], m[1:0], m[1]});
        end
    endtask
    task automatic t_compound();
        i_hub_cfg_source.put_compound(8'hFF);
        tick(2);
        check(rpt.report_compound, 1'b1);
        check(rpt.reported_fixed_ports, 4'hF);
        i_hub_cfg_source.get_byte(8'h09, d);
        check(d, 8'h1E);
        i_hub_cfg_source.put_byte(8'h07, 8'h00);
        tick(2);
        check(rpt.report_compound, 1'b0);
        pins(1'b1, 2'h2, 1'b1);
        check(rpt.report_compound, 1'b1);
        check(rpt.reported_fixed_ports, 4'h3);
        pins(1'b1, 2'h0, 1'b1);
        check(rpt.report_compound, 1'b0);
        pins(1'b0, 2'h0, 1'b1);
    endtask
    task automatic t_remap();
        i_hub_cfg_source.put_byte(8'h08, 8'h00);
        i_hub_cfg_source.put_byte(8'h0A, 8'h04);
        tick(2);
        check(rpt.enabled_port_count, 3'h3);
        check(rpt.logical_port_map, 12'h119);
        check(rpt.reported_fixed_ports, 4'hD);
        pins(1'b0, 2'h0, 1'b0);
        check(rpt.enabled_port_count, 3'h4);
        pins(1'b0, 2'h0, 1'b1);
        i_hub_cfg_source.put_byte(8'h08, 8'h08);
        tick(2);
        check(rpt.logical_port_map, 12'h8D1);
    endtask
    task automatic t_oc();
        for (int c = 0; c < 4; c++) begin
            i_hub_cfg_source.put_byte(8'h07, {2'h0, c[1:0], 4'h0});
            tick(2);
            @(posedge mclk);
            sense_n <= 4'hE;
            tick(3 + 2 * c);
            check(oc_valid, 4'h0);
            tick(1);
            check(oc_valid, 4'h1);
            tick(1);
            check(led2_n, 4'hE);
            @(posedge mclk);
            sense_n <= 4'hF;
            tick(2);
            check(oc_valid, 4'h0);
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        tick(2);
        t_reset();
        t_byte3();
        t_compound();
        t_remap();
        t_oc();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
